// [hdl/lcwc_codec.sv]
`timescale 1ns/10ps
`default_nettype none
module lcwc_codec
  import lcwc_pkg::*;
#(
  parameter int SKIP_N = lcwc_pkg::SKIP_INTERVAL // at most 5000
) (
  input wire logic mclk, // lane clock, 25 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic enc_ready, // encoder takes tx word this cycle
  input wire lcwc_pkg::lcwc_cmd_t cmd, // lane word requested
  input wire logic cmd_valid, // request pending
  output logic cmd_ready, // request taken this cycle
  input wire logic [7:0] capability, // own ability, sent in ack
  input wire lcwc_pkg::lcwc_word_t up_word, // frame or other word
  input wire logic up_valid, // upper word pending
  output logic up_ready, // upper word taken this cycle
  input wire logic tx_wake, // leave standby
  output lcwc_pkg::lcwc_word_t tx_word_ff, // word to encoder
  output logic tx_valid_ff, // tx word valid
  output logic drv_en_ff, // line driver enable
  input wire lcwc_pkg::lcwc_word_t rx_word, // decoded word
  input wire logic rx_valid, // rx word valid
  output lcwc_pkg::lcwc_kind_t rx_kind_ff, // kind of lane word
  output logic rx_kind_valid_ff, // one-cycle lane word pulse
  output logic rx_inverted_ff, // word was an inverted form
  output logic [7:0] rx_cap_ff, // far end capability
  output logic rx_unknown_ff // unrecognised comma word pulse
);
  import lcwc_pkg::*;

  // ----------------------------------------------------------------
  // transmit word selection
  // ----------------------------------------------------------------
  lcwc_txst_t st_ff;
  lcwc_txst_t nxt_st;
  logic [SKIP_CNT_W-1:0] skip_cnt_ff;
  logic [SKIP_CNT_W-1:0] nxt_skip_cnt;
  logic ack_pend_ff;
  logic skip_due;
  logic load;
  logic rx_recovery_clear_word;
  logic tx_lane_ff;
  lcwc_word_t nxt_word;
  logic nxt_lane;

  function automatic lcwc_word_t lane_word(input logic [7:0] t,
                                           input logic [7:0] last);
    lane_word.is_k = K_COMMA_ONLY;
    lane_word.sym = {last, t, SYM_LID, SYM_COMMA};
  endfunction

  function automatic logic [7:0] cmd_sym(input lcwc_cmd_t c);
    case (c)
      LCWC_CMD_INIT: cmd_sym = SYM_INIT;
      LCWC_CMD_INIT_ACKNOWLEDGE_WORD: cmd_sym = SYM_INIT_ACKNOWLEDGE_WORD;
      LCWC_CMD_RECOVERY_CLEAR_WORD: cmd_sym = SYM_RECOVERY_CLEAR_WORD;
      LCWC_CMD_RECOVERY_ACKNOWLEDGE_WORD: cmd_sym = SYM_RECOVERY_ACKNOWLEDGE_WORD;
      LCWC_CMD_STANDBY_WORD: cmd_sym = SYM_STANDBY_WORD;
      LCWC_CMD_LOS: cmd_sym = SYM_LOS;
      default: cmd_sym = SYM_IDLE;
    endcase
  endfunction

  assign load = enc_ready && (st_ff == LCWC_TX_RUN);
  assign skip_due = (skip_cnt_ff == SKIP_CNT_W'(SKIP_N - 1));
  // skip beats everything so the gap bound holds under any traffic
  assign cmd_ready = load && !skip_due && !ack_pend_ff;
  assign up_ready = cmd_ready && !cmd_valid;

  // priority: skip, owed acknowledge, lane command, upper word, idle
  always_comb begin
    nxt_lane = 1'b1;
    nxt_word = lane_word(SYM_IDLE, SYM_IDLE);
    if (skip_due) begin
      nxt_word = lane_word(SYM_SKIP, SYM_SKIP);
    end else if (ack_pend_ff) begin
      nxt_word = lane_word(SYM_RECOVERY_ACKNOWLEDGE_WORD, SYM_RECOVERY_ACKNOWLEDGE_WORD);
    end else if (cmd_valid) begin
      if (cmd == LCWC_CMD_INIT_ACKNOWLEDGE_WORD) begin
        nxt_word = lane_word(SYM_INIT_ACKNOWLEDGE_WORD, capability);
      end else begin
        nxt_word = lane_word(cmd_sym(cmd), cmd_sym(cmd));
      end
    end else if (up_valid) begin
      nxt_word = up_word;
      nxt_lane = 1'b0;
    end
  end

  // skip spacing counter, restarts on every skip sent
  always_comb begin
    nxt_skip_cnt = skip_cnt_ff;
    if (load) begin
      nxt_skip_cnt = skip_due ? SKIP_CNT_RST : skip_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      skip_cnt_ff <= SKIP_CNT_RST;
    end else begin
      skip_cnt_ff <= nxt_skip_cnt;
    end
  end

  // output word register, reloaded each time the encoder takes one while running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word_ff <= '0;
      tx_lane_ff <= 1'b0;
    end else if (load) begin
      tx_word_ff <= nxt_word;
      tx_lane_ff <= nxt_lane;
    end
  end

  // owed recovery acknowledge; a new clear wins over the send
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_pend_ff <= 1'b0;
    end else if (rx_recovery_clear_word) begin
      ack_pend_ff <= 1'b1;
    end else if (load && !skip_due) begin
      ack_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // standby sequencing
  // ----------------------------------------------------------------
  // the standby word must leave before the driver is released
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      LCWC_TX_RUN: begin
        if (cmd_ready && cmd_valid && cmd == LCWC_CMD_STANDBY_WORD) begin
          nxt_st = LCWC_TX_LAST;
        end
      end
      LCWC_TX_LAST: begin
        if (enc_ready) begin
          nxt_st = LCWC_TX_OFF;
        end
      end
      LCWC_TX_OFF: begin
        if (tx_wake) begin
          nxt_st = LCWC_TX_RUN;
        end
      end
      default: nxt_st = LCWC_TX_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= LCWC_TX_OFF;
      tx_valid_ff <= 1'b0;
      drv_en_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      tx_valid_ff <= (nxt_st != LCWC_TX_OFF) && (st_ff != LCWC_TX_OFF);
      drv_en_ff <= (nxt_st != LCWC_TX_OFF);
    end
  end

  // ----------------------------------------------------------------
  // receive decoder
  // ----------------------------------------------------------------
  logic rx_comma;
  logic rx_norm;
  logic rx_inv;
  logic rx_dup;
  logic [7:0] rx_t;
  lcwc_kind_t dec_kind;
  logic dec_inv;

  assign rx_comma = rx_valid && rx_word.sym[7:0] == SYM_COMMA &&
                    rx_word.is_k == K_COMMA_ONLY;
  assign rx_norm = rx_word.sym[15:8] == SYM_LID;
  assign rx_inv = rx_word.sym[15:8] == SYM_ILID;
  assign rx_t = rx_word.sym[23:16];
  assign rx_dup = rx_word.sym[31:24] == rx_t;
  assign rx_recovery_clear_word = rx_comma && dec_kind == LCWC_K_RECOVERY_CLEAR_WORD;

  // map identifier and type onto a kind; ack alone skips the copy check
  always_comb begin
    dec_kind = LCWC_K_NONE;
    dec_inv = 1'b0;
    if (rx_norm && rx_t == SYM_INIT_ACKNOWLEDGE_WORD) begin
      dec_kind = LCWC_K_INIT_ACKNOWLEDGE_WORD;
    end else if (rx_norm && rx_dup) begin
      case (rx_t)
        SYM_SKIP: dec_kind = LCWC_K_SKIP;
        SYM_IDLE: dec_kind = LCWC_K_IDLE;
        SYM_INIT: dec_kind = LCWC_K_INIT;
        SYM_RECOVERY_CLEAR_WORD: dec_kind = LCWC_K_RECOVERY_CLEAR_WORD;
        SYM_RECOVERY_ACKNOWLEDGE_WORD: dec_kind = LCWC_K_RECOVERY_ACKNOWLEDGE_WORD;
        SYM_STANDBY_WORD: dec_kind = LCWC_K_STANDBY_WORD;
        SYM_LOS: dec_kind = LCWC_K_LOS;
        default: dec_kind = LCWC_K_NONE;
      endcase
    end else if (rx_inv && rx_dup) begin
      dec_inv = 1'b1;
      case (rx_t)
        SYM_INVERTED_SKIP_WORD: dec_kind = LCWC_K_SKIP;
        SYM_INVERTED_IDLE_WORD: dec_kind = LCWC_K_IDLE;
        SYM_INVERTED_INIT_WORD: dec_kind = LCWC_K_INIT;
        default: dec_kind = LCWC_K_NONE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_kind_ff <= LCWC_K_NONE;
      rx_kind_valid_ff <= 1'b0;
      rx_inverted_ff <= 1'b0;
      rx_unknown_ff <= 1'b0;
    end else begin
      rx_kind_valid_ff <= rx_comma && dec_kind != LCWC_K_NONE;
      rx_unknown_ff <= rx_comma && dec_kind == LCWC_K_NONE;
      if (rx_comma) begin
        rx_kind_ff <= dec_kind;
        rx_inverted_ff <= dec_inv;
      end
    end
  end

  // far end capability held until the next acknowledge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cap_ff <= CAP_RST;
    end else if (rx_comma && dec_kind == LCWC_K_INIT_ACKNOWLEDGE_WORD) begin
      rx_cap_ff <= rx_word.sym[31:24];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [SKIP_CNT_W-1:0] gap_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= SKIP_CNT_RST;
    end else if (load) begin
      gap_ff <= (nxt_word.sym[23:16] == SYM_SKIP && nxt_lane) ?
                SKIP_CNT_RST : gap_ff + 1'b1;
    end
  end

  a_comma_first: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_lane_ff |-> tx_word_ff.sym[7:0] == SYM_COMMA &&
    tx_word_ff.is_k == K_COMMA_ONLY)
    else $error("lane word without leading comma");
  a_skip_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    gap_ff < SKIP_CNT_W'(SKIP_N))
    else $error("skip spacing exceeded");
  a_skip_format: assert property (@(posedge mclk) disable iff (!rst_n)
    load && skip_due |=> tx_word_ff.sym == {SYM_SKIP, SYM_SKIP,
    SYM_LID, SYM_COMMA})
    else $error("skip word malformed");
  a_inv_skip_rx: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_comma && rx_inv && rx_t == SYM_INVERTED_SKIP_WORD && rx_dup |=>
    rx_kind_valid_ff && rx_kind_ff == LCWC_K_SKIP && rx_inverted_ff)
    else $error("inverted skip not seen as skip");
  a_idle_fill: assert property (@(posedge mclk) disable iff (!rst_n)
    load && !skip_due && !ack_pend_ff && !cmd_valid && !up_valid |=>
    tx_word_ff.sym[31:16] == {SYM_IDLE, SYM_IDLE})
    else $error("idle not sent when nothing pending");
  a_inv_idle_rx: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_comma && rx_inv && rx_t == SYM_INVERTED_IDLE_WORD && rx_dup |=>
    rx_kind_ff == LCWC_K_IDLE)
    else $error("inverted idle not seen as idle");
  a_inv_init_rx: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_comma && rx_inv && rx_t == SYM_INVERTED_INIT_WORD && rx_dup |=>
    rx_kind_ff == LCWC_K_INIT && rx_inverted_ff)
    else $error("inverted init not flagged");
  a_recovery_clear_word_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_recovery_clear_word ##1 (load && !skip_due) |=>
    tx_word_ff.sym[23:16] == SYM_RECOVERY_ACKNOWLEDGE_WORD)
    else $error("recovery clear not acknowledged");
  a_standby_last: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(drv_en_ff) |-> tx_word_ff.sym[23:16] == SYM_STANDBY_WORD)
    else $error("driver off without standby word");
  a_no_inverted: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_lane_ff |-> tx_word_ff.sym[15:8] == SYM_LID)
    else $error("inverted lane word generated");
  a_unknown_only: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_unknown_ff |-> !rx_kind_valid_ff && rx_kind_ff == LCWC_K_NONE)
    else $error("unknown flag with valid kind");
endmodule // lcwc_codec
`default_nettype wire

// [hdl/lcwc_pkg.sv]
package lcwc_pkg;
  // ----------------------------------------------------------------
  // symbol values, Dx.y packed as {y, x}
  // ----------------------------------------------------------------
  localparam logic [7:0] SYM_COMMA = 8'hBC; // K28.5
  localparam logic [7:0] SYM_LID = 8'h23; // D3.1 lane word identifier
  localparam logic [7:0] SYM_ILID = 8'hDC; // D28.6 inverted identifier
  localparam logic [7:0] SYM_SKIP = 8'h26; // D6.1, even disparity
  localparam logic [7:0] SYM_IDLE = 8'h46; // D6.2
  localparam logic [7:0] SYM_INIT = 8'hA6; // D6.5
  localparam logic [7:0] SYM_INIT_ACKNOWLEDGE_WORD = 8'hC6; // D6.6
  localparam logic [7:0] SYM_RECOVERY_CLEAR_WORD = 8'h29; // D9.1
  localparam logic [7:0] SYM_RECOVERY_ACKNOWLEDGE_WORD = 8'h49; // D9.2
  localparam logic [7:0] SYM_STANDBY_WORD = 8'hA9; // D9.5
  localparam logic [7:0] SYM_LOS = 8'hC9; // D9.6
  localparam logic [7:0] SYM_INVERTED_SKIP_WORD = 8'hD9; // D25.6
  localparam logic [7:0] SYM_INVERTED_IDLE_WORD = 8'hB9; // D25.5
  localparam logic [7:0] SYM_INVERTED_INIT_WORD = 8'h59; // D25.2
  localparam logic [3:0] K_COMMA_ONLY = 4'h1; // only symbol 0 is k
  localparam int SKIP_INTERVAL = 5000; // words between skips, max
  localparam int SKIP_CNT_W = 13;
  localparam logic [SKIP_CNT_W-1:0] SKIP_CNT_RST = 13'h0000;
  localparam logic [7:0] CAP_RST = 8'h00;

  // one lane word, symbol 0 in bits 7:0 leaves first
  typedef struct packed {
    logic [3:0] is_k;
    logic [31:0] sym;
  } lcwc_word_t;

  // words the lane state machine may ask for; no inverted ones exist
  typedef enum logic [2:0] {
    LCWC_CMD_IDLE = 3'h0,
    LCWC_CMD_INIT = 3'h1,
    LCWC_CMD_INIT_ACKNOWLEDGE_WORD = 3'h2,
    LCWC_CMD_RECOVERY_CLEAR_WORD = 3'h3,
    LCWC_CMD_RECOVERY_ACKNOWLEDGE_WORD = 3'h4,
    LCWC_CMD_STANDBY_WORD = 3'h5,
    LCWC_CMD_LOS = 3'h6
  } lcwc_cmd_t;

  // kinds reported by the receive decoder
  typedef enum logic [3:0] {
    LCWC_K_NONE = 4'h0,
    LCWC_K_SKIP = 4'h1,
    LCWC_K_IDLE = 4'h2,
    LCWC_K_INIT = 4'h3,
    LCWC_K_INIT_ACKNOWLEDGE_WORD = 4'h4,
    LCWC_K_RECOVERY_CLEAR_WORD = 4'h5,
    LCWC_K_RECOVERY_ACKNOWLEDGE_WORD = 4'h6,
    LCWC_K_STANDBY_WORD = 4'h7,
    LCWC_K_LOS = 4'h8
  } lcwc_kind_t;

  // transmit power states, gray along run -> last -> off
  typedef enum logic [1:0] {
    LCWC_TX_RUN = 2'b00,
    LCWC_TX_LAST = 2'b01,
    LCWC_TX_OFF = 2'b11
  } lcwc_txst_t;
endpackage

// [sim/lcwc_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
module lcwc_far_end #(
  parameter int SKIP_N = 8 // skip spacing the codec was built with
) (
  input wire logic mclk, // lane clock
  input wire logic rst_n, // async reset, active low
  input wire logic slow, // encoder takes only every other edge
  input wire lcwc_pkg::lcwc_word_t tx_word_ff, // word offered by codec
  input wire logic tx_valid_ff, // offered word is meaningful
  output logic enc_ready, // encoder takes the word at this edge
  input wire logic rx_send, // far end puts a word on the lane
  input wire lcwc_pkg::lcwc_word_t rx_send_word, // that word
  output lcwc_pkg::lcwc_word_t rx_word, // decoded word to the codec
  output logic rx_valid, // decoded word valid
  output lcwc_pkg::lcwc_word_t last_word, // last word the encoder took
  output logic [15:0] loads, // words taken since reset
  output logic gap_err, // a skip came too late
  output logic inv_err // an inverted word was generated
);
  import lcwc_pkg::*;
  localparam logic [31:0] SKIP_SYM = {SYM_SKIP, SYM_SKIP, SYM_LID, SYM_COMMA};
  logic [31:0] filler;
  logic [15:0] gap;

  // encoder pace; a slow encoder exposes every ready-low path
  initial enc_ready = 1'b0;
  always @(posedge mclk) begin
    #1;
    enc_ready = slow ? !enc_ready : 1'b1;
  end

  // idle decoder output keeps moving so a stale word cannot pass as new
  initial filler = 32'h0000_0000;
  always @(posedge mclk) filler <= filler + 32'h0001_0003;
  assign rx_valid = rx_send;
  assign rx_word = rx_send ? rx_send_word : lcwc_word_t'({4'h0, filler});

  // watch every word the encoder takes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_word <= '0;
      loads <= 16'h0000;
      gap <= 16'h0000;
      gap_err <= 1'b0;
      inv_err <= 1'b0;
    end else if (enc_ready && tx_valid_ff) begin
      last_word <= tx_word_ff;
      loads <= loads + 16'h0001;
      gap <= (tx_word_ff.sym == SKIP_SYM) ? 16'h0000 : gap + 16'h0001;
      if (tx_word_ff.sym != SKIP_SYM && gap >= 16'(SKIP_N - 1)) begin
        gap_err <= 1'b1;
      end
      if (tx_word_ff.sym[15:8] == SYM_ILID) begin
        inv_err <= 1'b1;
      end
    end
  end
endmodule // lcwc_far_end
`default_nettype wire

// [sim/test_lcwc_codec.sv]
`timescale 1ns/10ps
`default_nettype none
module test_lcwc_codec;
  import lcwc_pkg::*;
  localparam int SKIP_N = 8;
  logic mclk, rst_n, slow, cmd_valid, cmd_ready, up_valid, up_ready;
  logic tx_wake, tx_valid_ff, drv_en_ff, enc_ready, rx_valid, rx_send;
  logic rx_kind_valid_ff, rx_inverted_ff, rx_unknown_ff, gap_err, inv_err;
  logic [7:0] capability, rx_cap_ff;
  logic [15:0] loads;
  lcwc_cmd_t cmd;
  lcwc_kind_t rx_kind_ff;
  lcwc_word_t up_word, tx_word_ff, rx_word, rx_send_word, last_word;
  int failures, checks_done;

  lcwc_codec #(.SKIP_N(SKIP_N)) dut (.mclk, .rst_n, .enc_ready, .cmd,
    .cmd_valid, .cmd_ready, .capability, .up_word, .up_valid, .up_ready,
    .tx_wake, .tx_word_ff, .tx_valid_ff, .drv_en_ff, .rx_word, .rx_valid,
    .rx_kind_ff, .rx_kind_valid_ff, .rx_inverted_ff, .rx_cap_ff,
    .rx_unknown_ff);
  lcwc_far_end #(.SKIP_N(SKIP_N)) far (.mclk, .rst_n, .slow, .tx_word_ff,
    .tx_valid_ff, .enc_ready, .rx_send, .rx_send_word, .rx_word, .rx_valid,
    .last_word, .loads, .gap_err, .inv_err);

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic lcwc_word_t lw(input logic [7:0] id, t3, t4);
    return '{is_k: 4'h1, sym: {t4, t3, id, SYM_COMMA}};
  endfunction

  task automatic check(input logic [35:0] seen, want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    $display("Error at %0t: wait ran out, seen 0 expected 1", $time);
    stop_test();
  endtask

  // hold the request until ready is seen high before the taking edge
  task automatic send(input logic use_cmd, input lcwc_cmd_t c,
      input lcwc_word_t exp);
    int n;
    // let an edge pass so a request is never dropped and raised in one step
    @(posedge mclk);
    #1;
    cmd = c;
    cmd_valid = use_cmd;
    up_valid = !use_cmd;
    for (n = 0; n < 60; n++) begin
      @(negedge mclk);
      if ((use_cmd ? cmd_ready : up_ready) === 1'b1) break;
    end
    if (n == 60) timeout();
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    up_valid = 1'b0;
    check(tx_word_ff, exp);
  endtask

  task automatic wait_load();
    logic [15:0] l0;
    int n;
    l0 = loads;
    for (n = 0; n < 20 && loads == l0; n++) begin
      @(posedge mclk);
      #1;
    end
    if (loads == l0) timeout();
  endtask

  // one received word; pulses must last exactly one cycle
  task automatic rx_one(input lcwc_word_t w, input logic kv, unk, inv,
      input lcwc_kind_t k);
    rx_send_word = w;
    rx_send = 1'b1;
    @(posedge mclk);
    #1;
    rx_send = 1'b0;
    check(36'({rx_kind_valid_ff, rx_unknown_ff}), 36'({kv, unk}));
    if (kv) begin
      check(36'({rx_kind_ff, rx_inverted_ff}), 36'({k, inv}));
    end
    @(posedge mclk);
    #1;
    check(36'({rx_kind_valid_ff, rx_unknown_ff}), 36'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wake();
    repeat (3) @(posedge mclk);
    #1;
    check(36'(drv_en_ff), 36'h0);
    tx_wake = 1'b1;
    @(posedge mclk);
    #1;
    tx_wake = 1'b0;
    check(36'({drv_en_ff, tx_valid_ff}), 36'h2);
    @(posedge mclk);
    #1;
    check(36'(tx_valid_ff), 36'h1);
    wait_load();
    wait_load();
    check(last_word, lw(SYM_LID, SYM_IDLE, SYM_IDLE));
  endtask

  // every command but standby, capability at both ends, then again with a slow encoder
  task automatic t_cmds();
    lcwc_cmd_t cs[8] = '{LCWC_CMD_INIT, LCWC_CMD_INIT_ACKNOWLEDGE_WORD, LCWC_CMD_INIT_ACKNOWLEDGE_WORD,
      LCWC_CMD_RECOVERY_CLEAR_WORD, LCWC_CMD_RECOVERY_ACKNOWLEDGE_WORD, LCWC_CMD_LOS, LCWC_CMD_IDLE,
      LCWC_CMD_INIT};
    logic [7:0] ts[8] = '{SYM_INIT, 8'h00, 8'hFF, SYM_RECOVERY_CLEAR_WORD, SYM_RECOVERY_ACKNOWLEDGE_WORD,
      SYM_LOS, SYM_IDLE, SYM_INIT};
    for (int i = 0; i < 16; i++) begin
      slow = (i >= 8);
      capability = ts[i % 8];
      send(1'b1, cs[i % 8], (cs[i % 8] == LCWC_CMD_INIT_ACKNOWLEDGE_WORD) ?
        lw(SYM_LID, SYM_INIT_ACKNOWLEDGE_WORD, ts[i % 8]) : lw(SYM_LID, ts[i % 8],
        ts[i % 8]));
    end
    slow = 1'b0;
    up_word = '{is_k: 4'h6, sym: 32'hDEAD_BEEF};
    send(1'b0, LCWC_CMD_IDLE, up_word);
  endtask

  task automatic t_skip();
    for (int n = 0; n < SKIP_N + 2; n++) begin
      wait_load();
      if (last_word.sym[23:16] == SYM_SKIP) break;
    end
    check(last_word, lw(SYM_LID, SYM_SKIP, SYM_SKIP));
    check(36'({gap_err, inv_err}), 36'h0);
  endtask

  task automatic t_rx();
    rx_one(lw(SYM_LID, SYM_SKIP, SYM_SKIP), 1, 0, 0, LCWC_K_SKIP);
    rx_one(lw(SYM_ILID, SYM_INVERTED_SKIP_WORD, SYM_INVERTED_SKIP_WORD), 1, 0, 1, LCWC_K_SKIP);
    rx_one(lw(SYM_LID, SYM_IDLE, SYM_IDLE), 1, 0, 0, LCWC_K_IDLE);
    rx_one(lw(SYM_ILID, SYM_INVERTED_IDLE_WORD, SYM_INVERTED_IDLE_WORD), 1, 0, 1, LCWC_K_IDLE);
    rx_one(lw(SYM_LID, SYM_INIT, SYM_INIT), 1, 0, 0, LCWC_K_INIT);
    rx_one(lw(SYM_ILID, SYM_INVERTED_INIT_WORD, SYM_INVERTED_INIT_WORD), 1, 0, 1, LCWC_K_INIT);
    rx_one(lw(SYM_LID, SYM_INIT_ACKNOWLEDGE_WORD, 8'h3C), 1, 0, 0, LCWC_K_INIT_ACKNOWLEDGE_WORD);
    rx_one(lw(SYM_LID, SYM_RECOVERY_ACKNOWLEDGE_WORD, SYM_RECOVERY_ACKNOWLEDGE_WORD), 1, 0, 0, LCWC_K_RECOVERY_ACKNOWLEDGE_WORD);
    rx_one(lw(SYM_LID, SYM_STANDBY_WORD, SYM_STANDBY_WORD), 1, 0, 0, LCWC_K_STANDBY_WORD);
    rx_one(lw(SYM_LID, SYM_LOS, SYM_LOS), 1, 0, 0, LCWC_K_LOS);
    check(36'(rx_cap_ff), 36'h3C);
    rx_one(lw(SYM_ILID, SYM_RECOVERY_CLEAR_WORD, SYM_RECOVERY_CLEAR_WORD), 0, 1, 0, LCWC_K_NONE);
    rx_one(lw(SYM_LID, SYM_SKIP, SYM_IDLE), 0, 1, 0, LCWC_K_NONE);
    rx_one(lcwc_word_t'({4'h0, 32'h2626_23BC}), 0, 0, 0,
      LCWC_K_NONE);
  endtask

  // a received clear must be answered without any command
  task automatic t_recovery_acknowledge_word();
    rx_one(lw(SYM_LID, SYM_RECOVERY_CLEAR_WORD, SYM_RECOVERY_CLEAR_WORD), 1, 0, 0, LCWC_K_RECOVERY_CLEAR_WORD);
    for (int n = 0; n < 5; n++) begin
      wait_load();
      if (last_word.sym[23:16] == SYM_RECOVERY_ACKNOWLEDGE_WORD) break;
    end
    check(last_word, lw(SYM_LID, SYM_RECOVERY_ACKNOWLEDGE_WORD, SYM_RECOVERY_ACKNOWLEDGE_WORD));
  endtask

  task automatic t_standby_word();
    send(1'b1, LCWC_CMD_STANDBY_WORD, lw(SYM_LID, SYM_STANDBY_WORD, SYM_STANDBY_WORD));
    @(posedge mclk);
    #1;
    check(36'({drv_en_ff, tx_valid_ff}), 36'h0);
    check(last_word, lw(SYM_LID, SYM_STANDBY_WORD, SYM_STANDBY_WORD));
    check(36'({gap_err, inv_err}), 36'h0);
  endtask

  // main sequence; reset held for five cycles
  initial begin
    failures = 0;
    checks_done = 0;
    rst_n = 1'b0;
    slow = 1'b0;
    cmd_valid = 1'b0;
    up_valid = 1'b0;
    tx_wake = 1'b0;
    rx_send = 1'b0;
    cmd = LCWC_CMD_IDLE;
    capability = 8'h00;
    up_word = '0;
    rx_send_word = '0;
    repeat (5) @(posedge mclk);
    #1;
    check(36'({drv_en_ff, tx_valid_ff, cmd_ready, up_ready}), 36'h0);
    rst_n = 1'b1;
    t_wake();
    t_cmds();
    t_skip();
    t_rx();
    t_recovery_acknowledge_word();
    t_standby_word();
    stop_test();
  end
endmodule // test_lcwc_codec
`default_nettype wire
